//--- verilog/pwm_action_regs.svh
/*
 * Register offsets, field positions, reset values and write mask of the
 * PWM output-action block.
 * Assumes byte addresses on a 12-bit register port with 32-bit data.
 */
`ifndef PWM_ACTION_REGS_SVH
`define PWM_ACTION_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OFF_GEN0_OUT_A 12'h060
`define OFF_GEN1_OUT_A 12'h0a0
`define OFF_GEN2_OUT_A 12'h0e0
`define OFF_GEN0_OUT_B 12'h064
`define OFF_GEN1_OUT_B 12'h0a4
`define OFF_GEN2_OUT_B 12'h0e4
`define OFF_GEN_MODE 12'h100
`define OFF_OUT_STATUS 12'h104

// ----------------------------------------------------------------------
// field positions (low bit of each 2-bit field)
// ----------------------------------------------------------------------
`define FLD_ZERO 0
`define FLD_LOAD 2
`define FLD_CMP_A_UP 4
`define FLD_CMP_A_DOWN 6
`define FLD_CMP_B_UP 8
`define FLD_CMP_B_DOWN 10
`define ACTION_FIELD_W 12
`define ACTION_WR_MASK 12'hfff

// ----------------------------------------------------------------------
// reset values and misc
// ----------------------------------------------------------------------
`define ACTION_RESET 12'h000
`define MODE_RESET 3'h0
`define RDATA_RESET 32'h0000_0000
`define MAX_GEN 3

`endif

//--- verilog/pwm_action_pkg.sv
/*
 * Types shared by the PWM output-action block.
 * Assumes the constants header is included by each module that needs it.
 */
package pwm_action_pkg;

    // ----------------------------------------------------------------------
    // output action encoding
    // ----------------------------------------------------------------------
    typedef enum logic [1:0] {
        ACT_HOLD   = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_LOW    = 2'b10,
        ACT_HIGH   = 2'b11
    } action_t;

    typedef logic [11:0] action_field_t;

endpackage

//--- verilog/pwm_event_qualify.sv
/*
 * Qualifies one generator's counter events by counting mode and direction.
 * Assumes the counter pulses are one cycle wide and synchronous to CLK.
 */
`timescale 1ns/1ps

module pwm_event_qualify (
    // counting mode and direction
    input wire logic updown_mode,
    input wire logic dir_up,
    // raw counter pulses
    input wire logic zero_pulse,
    input wire logic load_pulse,
    input wire logic cmp_a_match,
    input wire logic cmp_b_match,
    // qualified events
    output logic ev_zero,
    output logic ev_load,
    output logic ev_cmp_a_up,
    output logic ev_cmp_a_down,
    output logic ev_cmp_b_up,
    output logic ev_cmp_b_down
);

    logic counting_up;

    // down-only mode never counts up
    assign counting_up = updown_mode & dir_up;
    assign ev_zero = zero_pulse;
    assign ev_load = load_pulse;
    assign ev_cmp_a_up = cmp_a_match & counting_up;
    assign ev_cmp_b_up = cmp_b_match & counting_up;
    assign ev_cmp_a_down = cmp_a_match & ~counting_up;
    assign ev_cmp_b_down = cmp_b_match & ~counting_up;

endmodule

//--- verilog/pwm_action_resolve.sv
/*
 * Resolves coinciding events for one PWM output and holds its level.
 * Assumes qualified events from pwm_event_qualify and a stable action field.
 */
`timescale 1ns/1ps
`include "pwm_action_regs.svh"

module pwm_action_resolve #(
    parameter bit PREFER_CMP_B = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // action settings
    input wire logic [11:0] action_field,
    // qualified events
    input wire logic ev_zero,
    input wire logic ev_load,
    input wire logic ev_cmp_a_up,
    input wire logic ev_cmp_a_down,
    input wire logic ev_cmp_b_up,
    input wire logic ev_cmp_b_down,
    // output level
    output logic level
);

    logic next_level;
    pwm_action_pkg::action_t win_action;
    logic ev_a;
    logic ev_b;

    function automatic pwm_action_pkg::action_t field_at(input logic [11:0] f,
                                                          input int pos);
        return pwm_action_pkg::action_t'(f[pos +: 2]);
    endfunction

    assign ev_a = ev_cmp_a_up | ev_cmp_a_down;
    assign ev_b = ev_cmp_b_up | ev_cmp_b_down;

    // ----------------------------------------------------------------------
    // event priority
    // ----------------------------------------------------------------------
    always_comb begin
        win_action = pwm_action_pkg::ACT_HOLD;
        if (ev_zero) begin
            win_action = field_at(action_field, `FLD_ZERO);
        end else if (ev_load) begin
            win_action = field_at(action_field, `FLD_LOAD);
        end else if (ev_b && (PREFER_CMP_B || !ev_a)) begin
            // second output prefers compare B, first prefers compare A
            if (ev_cmp_b_up) begin
                win_action = field_at(action_field, `FLD_CMP_B_UP);
            end else begin
                win_action = field_at(action_field, `FLD_CMP_B_DOWN);
            end
        end else if (ev_a) begin
            if (ev_cmp_a_up) begin
                win_action = field_at(action_field, `FLD_CMP_A_UP);
            end else begin
                win_action = field_at(action_field, `FLD_CMP_A_DOWN);
            end
        end
    end

    // ----------------------------------------------------------------------
    // action decode
    // ----------------------------------------------------------------------
    always_comb begin
        case (win_action)
            pwm_action_pkg::ACT_HOLD: next_level = level;
            pwm_action_pkg::ACT_TOGGLE: next_level = ~level;
            pwm_action_pkg::ACT_LOW: next_level = 1'b0;
            pwm_action_pkg::ACT_HIGH: next_level = 1'b1;
            default: next_level = level;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level <= 1'b0;
        end else begin
            level <= next_level;
        end
    end

endmodule

//--- verilog/pwm_output_action_logic.sv
/*
 * Output-action logic for up to three PWM generators, two outputs each,
 * with the action registers, mode register and output status readback.
 * Assumes the counter and comparators deliver one-cycle pulses on CLK and
 * a master on the register port that never issues read and write together.
 */
//
// Notes on behaviour
// - field code 0 holds, 1 toggles, 2 drives low, 3 drives high.
// - bits 5:4 act on compare-A up match, only in up/down mode.
// - bits 3:2 act when the counter equals the load value.
// - bits 1:0 act when the counter reaches zero.
// - each generator's second output has its own register at 0x064/0x0A4/0x0E4.
// - down mode gives four event kinds, up/down mode all six.
// - zero or load beats any coinciding compare event.
// - second output: compare B beats coinciding compare A.
// - first output: compare A beats coinciding compare B.
// - bits 11:10 act on compare-B down match.
// - bits 9:8 compare-B up (up/down only); bits 7:6 compare-A down.
`timescale 1ns/1ps
`include "pwm_action_regs.svh"

module pwm_output_action_logic #(
    parameter int NUM_GEN = 3
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // register port
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [31:0] RDATA,
    // counter events, one bit per generator
    input wire logic [NUM_GEN-1:0] ZERO_PULSE,
    input wire logic [NUM_GEN-1:0] LOAD_PULSE,
    input wire logic [NUM_GEN-1:0] CMP_A_MATCH,
    input wire logic [NUM_GEN-1:0] CMP_B_MATCH,
    input wire logic [NUM_GEN-1:0] COUNT_DIR_UP,
    // pwm outputs
    output logic [NUM_GEN-1:0] GEN_OUT_FIRST,
    output logic [NUM_GEN-1:0] GEN_OUT_SECOND
);

    // ----------------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------------
    if (NUM_GEN < 1 || NUM_GEN > `MAX_GEN) begin : g_bad_num_gen
        $error("NUM_GEN must lie between 1 and 3");
    end

    // ----------------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------------
    function automatic logic [11:0] first_offset(input int g);
        case (g)
            0: return `OFF_GEN0_OUT_A;
            1: return `OFF_GEN1_OUT_A;
            2: return `OFF_GEN2_OUT_A;
            default: return `OFF_GEN0_OUT_A;
        endcase
    endfunction

    function automatic logic [11:0] second_offset(input int g);
        case (g)
            0: return `OFF_GEN0_OUT_B;
            1: return `OFF_GEN1_OUT_B;
            2: return `OFF_GEN2_OUT_B;
            default: return `OFF_GEN0_OUT_B;
        endcase
    endfunction

    function automatic logic hits(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    // ----------------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------------
    logic [11:0] first_action [NUM_GEN];
    logic [11:0] second_action [NUM_GEN];
    logic [11:0] next_first_action [NUM_GEN];
    logic [11:0] next_second_action [NUM_GEN];
    logic [NUM_GEN-1:0] generator_control;
    logic [NUM_GEN-1:0] next_generator_control;
    logic [31:0] next_rdata;

    always_comb begin
        for (int g = 0; g < NUM_GEN; g++) begin
            next_first_action[g] = first_action[g];
            next_second_action[g] = second_action[g];
            if (WR_EN && hits(ADDR, first_offset(g))) begin
                next_first_action[g] = WDATA[11:0] & `ACTION_WR_MASK;
            end
            // one register per generator for the second output
            if (WR_EN && hits(ADDR, second_offset(g))) begin
                next_second_action[g] = WDATA[11:0] & `ACTION_WR_MASK;
            end
        end
        next_generator_control = generator_control;
        if (WR_EN && hits(ADDR, `OFF_GEN_MODE)) begin
            next_generator_control = WDATA[NUM_GEN-1:0];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int g = 0; g < NUM_GEN; g++) begin
                first_action[g] <= `ACTION_RESET;
                second_action[g] <= `ACTION_RESET;
            end
            generator_control <= NUM_GEN'(`MODE_RESET);
        end else begin
            for (int g = 0; g < NUM_GEN; g++) begin
                first_action[g] <= next_first_action[g];
                second_action[g] <= next_second_action[g];
            end
            generator_control <= next_generator_control;
        end
    end

    // ----------------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------------
    always_comb begin
        next_rdata = `RDATA_RESET;
        if (RD_EN) begin
            for (int g = 0; g < NUM_GEN; g++) begin
                if (hits(ADDR, first_offset(g))) begin
                    next_rdata = {20'h0_0000, first_action[g]};
                end
                if (hits(ADDR, second_offset(g))) begin
                    next_rdata = {20'h0_0000, second_action[g]};
                end
            end
            if (hits(ADDR, `OFF_GEN_MODE)) begin
                next_rdata[NUM_GEN-1:0] = generator_control;
            end
            if (hits(ADDR, `OFF_OUT_STATUS)) begin
                next_rdata[NUM_GEN-1:0] = GEN_OUT_FIRST;
                next_rdata[NUM_GEN+3:4] = GEN_OUT_SECOND;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA <= `RDATA_RESET;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // ----------------------------------------------------------------------
    // per-generator event and output logic
    // ----------------------------------------------------------------------
    for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
        logic ev_zero;
        logic ev_load;
        logic ev_cmp_a_up;
        logic ev_cmp_a_down;
        logic ev_cmp_b_up;
        logic ev_cmp_b_down;

        // mode bit decides which compare events exist
        pwm_event_qualify u_qualify (
            .updown_mode(generator_control[g]),
            .dir_up(COUNT_DIR_UP[g]),
            .zero_pulse(ZERO_PULSE[g]),
            .load_pulse(LOAD_PULSE[g]),
            .cmp_a_match(CMP_A_MATCH[g]),
            .cmp_b_match(CMP_B_MATCH[g]),
            .ev_zero(ev_zero),
            .ev_load(ev_load),
            .ev_cmp_a_up(ev_cmp_a_up),
            .ev_cmp_a_down(ev_cmp_a_down),
            .ev_cmp_b_up(ev_cmp_b_up),
            .ev_cmp_b_down(ev_cmp_b_down)
        );

        // first output favours compare A
        pwm_action_resolve #(
            .PREFER_CMP_B(1'b0)
        ) u_first (
            .clk(CLK),
            .reset_n(RESET_N),
            .action_field(first_action[g]),
            .ev_zero(ev_zero),
            .ev_load(ev_load),
            .ev_cmp_a_up(ev_cmp_a_up),
            .ev_cmp_a_down(ev_cmp_a_down),
            .ev_cmp_b_up(ev_cmp_b_up),
            .ev_cmp_b_down(ev_cmp_b_down),
            .level(GEN_OUT_FIRST[g])
        );

        // second output favours compare B
        pwm_action_resolve #(
            .PREFER_CMP_B(1'b1)
        ) u_second (
            .clk(CLK),
            .reset_n(RESET_N),
            .action_field(second_action[g]),
            .ev_zero(ev_zero),
            .ev_load(ev_load),
            .ev_cmp_a_up(ev_cmp_a_up),
            .ev_cmp_a_down(ev_cmp_a_down),
            .ev_cmp_b_up(ev_cmp_b_up),
            .ev_cmp_b_down(ev_cmp_b_down),
            .level(GEN_OUT_SECOND[g])
        );
    end

endmodule

//--- dv/pwm_output_action_asserts.sv
/*
 * Port-level assertions for the PWM output-action block.
 * Assumes it is bound to the top module; it shadows the generator 0 fields.
 */
`timescale 1ns/1ps
`include "pwm_action_regs.svh"

module pwm_output_action_asserts #(
    parameter int NUM_GEN = 3
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // register port
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [31:0] RDATA,
    // counter events
    input wire logic [NUM_GEN-1:0] ZERO_PULSE,
    input wire logic [NUM_GEN-1:0] LOAD_PULSE,
    input wire logic [NUM_GEN-1:0] CMP_A_MATCH,
    input wire logic [NUM_GEN-1:0] CMP_B_MATCH,
    input wire logic [NUM_GEN-1:0] COUNT_DIR_UP,
    // pwm outputs
    input wire logic [NUM_GEN-1:0] GEN_OUT_FIRST,
    input wire logic [NUM_GEN-1:0] GEN_OUT_SECOND
);
    logic [11:0] a0;
    logic [11:0] b0;
    logic ev0;
    logic cmp_dn0;

    assign ev0 = ZERO_PULSE[0] | LOAD_PULSE[0] | CMP_A_MATCH[0] | CMP_B_MATCH[0];
    assign cmp_dn0 = !ZERO_PULSE[0] && !LOAD_PULSE[0] && !COUNT_DIR_UP[0];

    // shadow of generator 0 action fields
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            a0 <= 12'h000;
            b0 <= 12'h000;
        end else if (WR_EN && ADDR == `OFF_GEN0_OUT_A) begin
            a0 <= WDATA[11:0];
        end else if (WR_EN && ADDR == `OFF_GEN0_OUT_B) begin
            b0 <= WDATA[11:0];
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    a_first_hold: assert property (!ev0 |=> $stable(GEN_OUT_FIRST[0]))
        else $error("first output moved without event");
    a_second_hold: assert property (!ev0 |=> $stable(GEN_OUT_SECOND[0]))
        else $error("second output moved without event");
    a_zero_high: assert property (ZERO_PULSE[0] && a0[1:0] == 2'h3 |=> GEN_OUT_FIRST[0])
        else $error("zero set action missed");
    a_zero_low: assert property (ZERO_PULSE[0] && b0[1:0] == 2'h2 |=> !GEN_OUT_SECOND[0])
        else $error("zero clear action missed");
    a_load_toggle: assert property (LOAD_PULSE[0] && !ZERO_PULSE[0] && a0[3:2] == 2'h1
        |=> GEN_OUT_FIRST[0] != $past(GEN_OUT_FIRST[0]))
        else $error("load toggle action missed");
    a_cmp_b_wins: assert property (CMP_B_MATCH[0] && cmp_dn0 && b0[11:10] == 2'h3
        |=> GEN_OUT_SECOND[0])
        else $error("compare B down action missed");
    a_cmp_a_wins: assert property (CMP_A_MATCH[0] && cmp_dn0 && a0[7:6] == 2'h2
        |=> !GEN_OUT_FIRST[0])
        else $error("compare A down action missed");
    a_rdata_idle: assert property (!RD_EN |=> RDATA == 32'h0000_0000)
        else $error("read data not zero outside read");
    a_rdata_upper: assert property (RD_EN |=> RDATA[31:12] == 20'h0_0000)
        else $error("reserved read bits not zero");
endmodule

bind pwm_output_action_logic pwm_output_action_asserts #(.NUM_GEN(NUM_GEN))
    pwm_output_action_asserts_inst (.CLK, .RESET_N, .ADDR, .WDATA, .WR_EN, .RD_EN, .RDATA,
    .ZERO_PULSE, .LOAD_PULSE, .CMP_A_MATCH, .CMP_B_MATCH, .COUNT_DIR_UP, .GEN_OUT_FIRST,
    .GEN_OUT_SECOND);

//--- dv/tb_top.sv
/*
 * Self-checking bench for the PWM output-action block with a cycle model.
 * Assumes the design files and the checker are compiled before it.
 */
`timescale 1ns/1ps
`include "pwm_action_regs.svh"

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [2:0] zero_p = 3'h0;
    logic [2:0] load_p = 3'h0;
    logic [2:0] cmp_a = 3'h0;
    logic [2:0] cmp_b = 3'h0;
    logic [2:0] dir_up = 3'h0;
    logic [2:0] out_a;
    logic [2:0] out_b;
    logic [11:0] act [6];
    logic [2:0] mode;
    logic [2:0] exp_a;
    logic [2:0] exp_b;
    logic [31:0] exp_rd;
    logic up;
    logic [11:0] regs [8] = '{`OFF_GEN0_OUT_A, `OFF_GEN0_OUT_B, `OFF_GEN1_OUT_A,
        `OFF_GEN1_OUT_B, `OFF_GEN2_OUT_A, `OFF_GEN2_OUT_B, `OFF_GEN_MODE, `OFF_OUT_STATUS};
    int seed = 43;
    int err_count = 0;
    int checks = 0;

    always #2 clk = ~clk;

    pwm_output_action_logic #(.NUM_GEN(3)) pwm_output_action_logic_inst (
        .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR_EN(wr_en),
        .RD_EN(rd_en), .RDATA(rdata), .ZERO_PULSE(zero_p), .LOAD_PULSE(load_p),
        .CMP_A_MATCH(cmp_a), .CMP_B_MATCH(cmp_b), .COUNT_DIR_UP(dir_up),
        .GEN_OUT_FIRST(out_a), .GEN_OUT_SECOND(out_b));

    // ----------------------------------------------------------------------
    // reference model
    // ----------------------------------------------------------------------
    function automatic logic nxt(logic [11:0] f, logic cur, logic z, logic l, logic a,
        logic b, logic u, logic pb);
        logic [1:0] c;
        c = 2'h0;
        if (z) c = f[1:0];
        else if (l) c = f[3:2];
        else if (a && !(b && pb)) c = u ? f[5:4] : f[7:6];
        else if (b) c = u ? f[9:8] : f[11:10];
        case (c)
            2'h1: return !cur;
            2'h2: return 1'b0;
            2'h3: return 1'b1;
            default: return cur;
        endcase
    endfunction

    function automatic logic [31:0] rd_model(logic [11:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = 0; i < 6; i++) if (a == regs[i]) r = {20'h0_0000, act[i]};
        if (a == `OFF_GEN_MODE) r = {29'h0000_0000, mode};
        if (a == `OFF_OUT_STATUS) r = {25'h000_0000, exp_b, 1'b0, exp_a};
        return r;
    endfunction

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 6; i++) act[i] = 12'h000;
            mode = 3'h0;
            exp_a = 3'h0;
            exp_b = 3'h0;
            exp_rd = 32'h0000_0000;
        end else begin
            exp_rd = rd_en ? rd_model(addr) : 32'h0000_0000;
            for (int g = 0; g < 3; g++) begin
                up = mode[g] && dir_up[g];
                exp_a[g] = nxt(act[2*g], exp_a[g], zero_p[g], load_p[g], cmp_a[g], cmp_b[g],
                    up, 1'b0);
                exp_b[g] = nxt(act[2*g+1], exp_b[g], zero_p[g], load_p[g], cmp_a[g], cmp_b[g],
                    up, 1'b1);
            end
            if (wr_en) begin
                for (int i = 0; i < 6; i++) if (addr == regs[i]) act[i] = wdata[11:0];
                if (addr == `OFF_GEN_MODE) mode = wdata[2:0];
            end
        end
    end

    always @(negedge clk) begin
        `CHK(out_a, exp_a)
        `CHK(out_b, exp_b)
        `CHK(rdata, exp_rd)
    end

    // ----------------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------------
    function automatic logic [2:0] ev();
        return 3'($random(seed) & $random(seed));
    endfunction

    task automatic step(logic w, logic r, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        wr_en <= w;
        rd_en <= r;
        addr <= a;
        wdata <= d;
        zero_p <= ev();
        load_p <= ev();
        cmp_a <= ev();
        cmp_b <= ev();
        dir_up <= 3'($random(seed));
    endtask

    task automatic run_random(int n);
        logic [31:0] r;
        for (int k = 0; k < n; k++) begin
            r = $random(seed);
            step(r[4] & r[5], !(r[4] & r[5]) & r[6], (r[3] & r[7]) ? r[31:20] : regs[r[2:0]],
                32'($random(seed)));
        end
    endtask

    task automatic read_all();
        for (int i = 0; i < 8; i++) step(1'b0, 1'b1, regs[i], 32'h0000_0000);
    endtask

    task report_and_stop();
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #100_000;
        err_count++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        read_all();
        for (int i = 0; i < 8; i++) step(1'b1, 1'b0, regs[i], 32'hffff_ffff);
        read_all();
        $display("test all_ones done");
        run_random(3000);
        $display("test random_a done");
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        read_all();
        $display("test mid_reset done");
        run_random(1500);
        step(1'b0, 1'b0, 12'h000, 32'h0000_0000);
        repeat (2) @(posedge clk);
        $display("test random_b done");
        report_and_stop();
    end
endmodule
